// *** design/hac_pkg.sv ***
// constants and types of the host adapter command port
package hac_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DATAIN = 8'h08;
    localparam logic [7:0] ADDR_INTR = 8'h0c;
    localparam logic [7:0] ADDR_MBXCFG = 8'h10;
    // status register bits
    localparam int ST_READY = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_REPLY_RDY = 2;
    localparam int ST_INIT_REQ = 3;
    localparam int ST_INVALID = 4;
    localparam int ST_SCANNING = 5;
    localparam int ST_OUTRDY_EN = 6;
    // interrupt register bits, write one to clear bits 0 and 1; bit 7 is their or
    localparam int IR_COMPLETE = 0;
    localparam int IR_OUT_READY = 1;
    localparam int IR_ANY = 7;
    // opcodes handled here
    localparam logic [7:0] OP_TEST = 8'h00;
    localparam logic [7:0] OP_MBXINIT = 8'h01;
    localparam logic [7:0] OP_SCAN = 8'h02;
    localparam logic [7:0] OP_BIOS = 8'h03;
    localparam logic [7:0] OP_BOARDID = 8'h04;
    localparam logic [7:0] OP_OUTRDYEN = 8'h05;
    // byte counts
    localparam logic [2:0] INIT_PARAMS = 3'h4;
    localparam logic [2:0] OUTRDY_PARAMS = 3'h1;
    localparam logic [2:0] ID_REPLIES = 3'h4;
    localparam logic [23:0] ENTRY_BYTES = 24'h000004;
    // reset values
    localparam logic RST_INIT_REQ = 1'b1;
    // every defined opcode
    localparam int N_OPS = 24;
    localparam logic [7:0] OP_TABLE [N_OPS] = '{
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h1a, 8'h1b,
        8'h1c, 8'h1d, 8'h1f, 8'h20, 8'h21, 8'h8d, 8'h9a, 8'h9b};
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PARAM = 2'b01,
        ST_EXEC = 2'b10,
        ST_REPLY = 2'b11
    } hac_state_t;
endpackage

// *** design/hac_cmd_decode.sv ***
// opcode table lookup: known flag and byte counts
`timescale 1ns/1ps
`default_nettype none
module hac_cmd_decode #(
    parameter int NOPS = hac_pkg::N_OPS
) (
    // opcode in
    input wire logic [7:0] opcode,
    // decode out
    output logic known,
    output logic [2:0] paramCount,
    output logic [2:0] replyCount
);
    import hac_pkg::*;
    logic [NOPS-1:0] hit;
    genvar i;
    // one comparator per table entry
    generate
        for (i = 0; i < NOPS; i++)
        begin : g_op
            assign hit[i] = (opcode == OP_TABLE[i]);
        end
    endgenerate
    assign known = |hit;
    // counts only for commands carried out in this block
    always_comb
    begin
        paramCount = 3'h0;
        replyCount = 3'h0;
        if (opcode == OP_MBXINIT)
            paramCount = INIT_PARAMS;
        else if (opcode == OP_OUTRDYEN)
            paramCount = OUTRDY_PARAMS;
        else if (opcode == OP_BOARDID)
            replyCount = ID_REPLIES;
    end
endmodule
`default_nettype wire

// *** design/hac_mbx_scan.sv ***
// outgoing mailbox walker
`timescale 1ns/1ps
`default_nettype none
module hac_mbx_scan #(
    parameter int AW = 24
) (
    // clock, reset and enable
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    // control
    input wire logic start,
    input wire logic [7:0] count,
    input wire logic [AW-1:0] base,
    // entry handshake
    input wire logic entryAck,
    output logic scanActive_ff,
    output logic [AW-1:0] outAddr_ff,
    output logic [AW-1:0] inAddr_ff,
    output logic entryDone_ff
);
    import hac_pkg::*;
    logic [7:0] idx_ff;
    logic lastEntry;
    assign lastEntry = (idx_ff == count - 8'h01);
    // walk: out array first, in array right after it
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            scanActive_ff <= 1'b0;
            idx_ff <= 8'h00;
            outAddr_ff <= '0;
            inAddr_ff <= '0;
            entryDone_ff <= 1'b0;
        end
        else if (ce)
        begin
            entryDone_ff <= scanActive_ff && entryAck;
            if (start && !scanActive_ff)
            begin
                scanActive_ff <= 1'b1;
                idx_ff <= 8'h00;
                outAddr_ff <= base;
                inAddr_ff <= base + AW'({count, 2'b00});
            end
            else if (scanActive_ff && entryAck)
            begin
                idx_ff <= idx_ff + 8'h01;
                outAddr_ff <= outAddr_ff + AW'(ENTRY_BYTES);
                inAddr_ff <= inAddr_ff + AW'(ENTRY_BYTES);
                if (lastEntry)
                    scanActive_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/hac_cmd_port.sv ***
// command/parameter interpreter with apb register access
`timescale 1ns/1ps
`default_nettype none
module hac_cmd_port #(
    parameter logic [7:0] BOARD_TYPE = 8'h5a, // arbitrary value
    parameter logic [7:0] FEATURE_CODE = 8'h5b, // arbitrary value
    parameter logic [7:0] FW_REVISION = 8'h33, // ascii digit
    parameter logic [7:0] FW_VERSION = 8'h31
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mailbox entry handshake
    input wire logic mbxEntryAck,
    output logic mbxScanActive,
    output logic [23:0] mbxOutAddr,
    output logic [23:0] mbxInAddr
);
    import hac_pkg::*;
    hac_state_t state_ff, nxt_state;
    logic [7:0] opcode_ff;
    logic [7:0] param_ff [4];
    logic [2:0] pIdx_ff;
    logic [2:0] rIdx_ff;
    logic adapterReady_ff, paramBusy_ff, replyReady_ff;
    logic commandComplete_ff, commandInvalid_ff;
    logic initRequired_ff, mbxInit_ff, outReadyEnable_ff, outMailboxReady_ff;
    logic [7:0] mbxCount_ff, dataIn_ff;
    logic [23:0] mbxBase_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic known, mapped;
    logic [2:0] paramCount;
    logic [7:0] wByte, replyByte;
    logic xfer, wrCmd, rdData, clrComplete, clrOutReady;
    logic exempt, takeOpcode, takeParam, lastParam, execOp;
    logic setComplete, setInvalid, scanStart, entryDone;

    // apb completes on the second access edge
    assign xfer = ce && psel && penable && pready_ff;
    assign wByte = pwdata[7:0];
    assign wrCmd = xfer && pwrite && (paddr == ADDR_CMD);
    assign rdData = xfer && !pwrite && (paddr == ADDR_DATAIN);
    assign clrComplete = xfer && pwrite && (paddr == ADDR_INTR) && pwdata[IR_COMPLETE];
    assign clrOutReady = xfer && pwrite && (paddr == ADDR_INTR) && pwdata[IR_OUT_READY];
    assign mapped = (paddr == ADDR_CMD) || (paddr == ADDR_STATUS) ||
        (paddr == ADDR_DATAIN) || (paddr == ADDR_INTR) || (paddr == ADDR_MBXCFG);

    hac_cmd_decode u_decode (
        .opcode(state_ff == ST_PARAM ? opcode_ff : wByte),
        .known(known),
        .paramCount(paramCount),
        .replyCount()
    );

    // scan and ready-interrupt enable may cut into a pending reply
    assign exempt = (wByte == OP_SCAN) || (wByte == OP_OUTRDYEN);
    assign takeOpcode = wrCmd && (state_ff == ST_IDLE ||
        (state_ff == ST_REPLY && exempt));
    assign takeParam = wrCmd && (state_ff == ST_PARAM) && !paramBusy_ff;
    assign lastParam = (pIdx_ff == paramCount - 3'h1);
    assign execOp = ce && (state_ff == ST_EXEC);

    // next state
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE, ST_REPLY:
            begin
                if (takeOpcode)
                begin
                    if (!known)
                        nxt_state = ST_IDLE;
                    else if (paramCount != 3'h0)
                        nxt_state = ST_PARAM;
                    else
                        nxt_state = ST_EXEC;
                end
                else if (state_ff == ST_REPLY && rdData && replyReady_ff &&
                    rIdx_ff == ID_REPLIES - 3'h1)
                    nxt_state = ST_IDLE;
            end
            ST_PARAM:
                if (takeParam && lastParam)
                    nxt_state = ST_EXEC;
            ST_EXEC:
                nxt_state = (opcode_ff == OP_BOARDID) ? ST_REPLY : ST_IDLE;
        endcase
    end

    // command sequencing, opcode and parameter capture
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= ST_IDLE;
            opcode_ff <= 8'h00;
            pIdx_ff <= 3'h0;
            for (int k = 0; k < 4; k++)
                param_ff[k] <= 8'h00;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            if (takeOpcode)
            begin
                opcode_ff <= wByte;
                pIdx_ff <= 3'h0;
            end
            else if (takeParam)
            begin
                param_ff[pIdx_ff[1:0]] <= wByte;
                pIdx_ff <= pIdx_ff + 3'h1;
            end
        end
    end

    // ready and busy follow the command phase
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            adapterReady_ff <= 1'b1;
            paramBusy_ff <= 1'b0;
        end
        else if (ce)
        begin
            adapterReady_ff <= (nxt_state == ST_IDLE);
            paramBusy_ff <= (nxt_state == ST_EXEC) || (nxt_state == ST_REPLY);
        end
    end

    // completion and error events of each command
    always_comb
    begin
        setComplete = 1'b0;
        setInvalid = 1'b0;
        scanStart = 1'b0;
        if (ce && takeOpcode && !known)
        begin
            setComplete = 1'b1;
            setInvalid = 1'b1;
        end
        else if (execOp)
        begin
            unique case (opcode_ff)
                OP_TEST, OP_BIOS:
                    setComplete = 1'b1;
                OP_MBXINIT:
                begin
                    setComplete = 1'b1;
                    setInvalid = (param_ff[0] == 8'h00);
                end
                OP_SCAN:
                begin
                    setComplete = !mbxInit_ff;
                    setInvalid = !mbxInit_ff;
                    scanStart = mbxInit_ff;
                end
                OP_OUTRDYEN:
                begin
                    setComplete = (param_ff[0] > 8'h01);
                    setInvalid = (param_ff[0] > 8'h01);
                end
                OP_BOARDID:
                    setComplete = 1'b0;
                default:
                    setComplete = 1'b1; // accepted, no effect here
            endcase
        end
        else if (ce && state_ff == ST_REPLY && rdData && replyReady_ff &&
            rIdx_ff == ID_REPLIES - 3'h1)
            setComplete = 1'b1;
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            commandComplete_ff <= 1'b0;
            commandInvalid_ff <= 1'b0;
            outMailboxReady_ff <= 1'b0;
        end
        else if (ce)
        begin
            commandComplete_ff <= setComplete || (commandComplete_ff && !clrComplete);
            commandInvalid_ff <= setInvalid || (commandInvalid_ff && !clrComplete);
            outMailboxReady_ff <= (entryDone && outReadyEnable_ff) ||
                (outMailboxReady_ff && !clrOutReady);
        end
    end

    // mailbox setup and ready-interrupt option
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            initRequired_ff <= RST_INIT_REQ;
            mbxInit_ff <= 1'b0;
            mbxCount_ff <= 8'h00;
            mbxBase_ff <= 24'h000000;
            outReadyEnable_ff <= 1'b0;
        end
        else if (execOp)
        begin
            if (opcode_ff == OP_MBXINIT && param_ff[0] != 8'h00)
            begin
                mbxCount_ff <= param_ff[0];
                mbxBase_ff <= {param_ff[1], param_ff[2], param_ff[3]};
                mbxInit_ff <= 1'b1;
                initRequired_ff <= 1'b0;
            end
            if (opcode_ff == OP_OUTRDYEN && param_ff[0] <= 8'h01)
                outReadyEnable_ff <= param_ff[0][0];
        end
    end

    // reply bytes in order
    always_comb
    begin
        unique case (rIdx_ff[1:0])
            2'b00: replyByte = BOARD_TYPE;
            2'b01: replyByte = FEATURE_CODE;
            2'b10: replyByte = FW_REVISION;
            2'b11: replyByte = FW_VERSION;
        endcase
    end

    // data-in handshake: load, flag, wait for read, advance
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rIdx_ff <= 3'h0;
            replyReady_ff <= 1'b0;
            dataIn_ff <= 8'h00;
        end
        else if (ce)
        begin
            if (state_ff != ST_REPLY || takeOpcode)
            begin
                rIdx_ff <= 3'h0;
                replyReady_ff <= 1'b0;
            end
            else if (rdData && replyReady_ff)
            begin
                replyReady_ff <= 1'b0;
                rIdx_ff <= rIdx_ff + 3'h1;
            end
            else if (!replyReady_ff && rIdx_ff < ID_REPLIES)
            begin
                dataIn_ff <= replyByte;
                replyReady_ff <= 1'b1;
            end
        end
    end

    hac_mbx_scan #(.AW(24)) u_scan (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .start(scanStart),
        .count(mbxCount_ff),
        .base(mbxBase_ff),
        .entryAck(mbxEntryAck),
        .scanActive_ff(mbxScanActive),
        .outAddr_ff(mbxOutAddr),
        .inAddr_ff(mbxInAddr),
        .entryDone_ff(entryDone)
    );

    // apb: one wait state, read data frozen before pready
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else if (ce)
        begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !mapped;
            if (psel && penable && !pready_ff && !pwrite)
            begin
                prdata_ff <= 32'h00000000;
                if (paddr == ADDR_STATUS)
                    prdata_ff <= {25'h0, outReadyEnable_ff, mbxScanActive,
                        commandInvalid_ff, initRequired_ff, replyReady_ff,
                        paramBusy_ff, adapterReady_ff};
                else if (paddr == ADDR_DATAIN)
                    prdata_ff <= {24'h0, dataIn_ff};
                else if (paddr == ADDR_INTR)
                    prdata_ff <= {24'h0, commandComplete_ff || outMailboxReady_ff,
                        5'h0, outMailboxReady_ff, commandComplete_ff};
                else if (paddr == ADDR_MBXCFG)
                    prdata_ff <= {mbxCount_ff, mbxBase_ff};
            end
        end
    end
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // checks
    sequence idExec_s;
        ce && state_ff == ST_EXEC && opcode_ff == OP_BOARDID;
    endsequence
    sequence firstByte_s;
        state_ff == ST_REPLY ##[1:3] replyReady_ff && dataIn_ff == BOARD_TYPE;
    endsequence
    readyPhase_a: assert property (@(posedge clock) disable iff (!resetn)
        adapterReady_ff == (state_ff == ST_IDLE))
        else $error("ready flag disagrees with command phase");
    busyExec_a: assert property (@(posedge clock) disable iff (!resetn)
        state_ff == ST_EXEC |-> paramBusy_ff)
        else $error("busy low while executing");
    testOp_a: assert property (@(posedge clock) disable iff (!resetn)
        execOp && opcode_ff == OP_TEST |=> commandComplete_ff && !commandInvalid_ff)
        else $error("test opcode did not complete");
    zeroCount_a: assert property (@(posedge clock) disable iff (!resetn)
        execOp && opcode_ff == OP_MBXINIT && param_ff[0] == 8'h00
        |=> commandComplete_ff && commandInvalid_ff && $stable(initRequired_ff))
        else $error("zero mailbox count not flagged");
    initDone_a: assert property (@(posedge clock) disable iff (!resetn)
        execOp && opcode_ff == OP_MBXINIT && param_ff[0] != 8'h00
        |=> commandComplete_ff && !initRequired_ff && mbxInit_ff)
        else $error("mailbox init did not finish");
    scanQuiet_a: assert property (@(posedge clock) disable iff (!resetn)
        execOp && opcode_ff == OP_SCAN && mbxInit_ff && !commandComplete_ff
        |=> !commandComplete_ff && mbxScanActive)
        else $error("scan raised complete or did not start");
    scanEarly_a: assert property (@(posedge clock) disable iff (!resetn)
        execOp && opcode_ff == OP_SCAN && !mbxInit_ff
        |=> commandComplete_ff && commandInvalid_ff)
        else $error("scan before init not flagged");
    replyClear_a: assert property (@(posedge clock) disable iff (!resetn)
        ce && rdData && replyReady_ff && state_ff == ST_REPLY |=> !replyReady_ff)
        else $error("reply ready not cleared by read");
    replyFirst_a: assert property (@(posedge clock) disable iff (!resetn)
        idExec_s |=> firstByte_s)
        else $error("first id byte not offered");
    badOp_a: assert property (@(posedge clock) disable iff (!resetn)
        ce && takeOpcode && !known
        |=> commandComplete_ff && commandInvalid_ff && state_ff == ST_IDLE)
        else $error("unknown opcode not rejected");
    enableBad_a: assert property (@(posedge clock) disable iff (!resetn)
        execOp && opcode_ff == OP_OUTRDYEN && param_ff[0] > 8'h01
        |=> commandInvalid_ff && commandComplete_ff && $stable(outReadyEnable_ff))
        else $error("bad enable byte not flagged");
    exemptOp_a: assert property (@(posedge clock) disable iff (!resetn)
        ce && wrCmd && state_ff == ST_REPLY && wByte == OP_SCAN |=> state_ff == ST_EXEC)
        else $error("scan opcode refused during reply");
endmodule
`default_nettype wire

// *** dv/hac_mbx_model.sv ***
// mailbox servicer model that answers outgoing entry requests
`timescale 1ns/1ps
`default_nettype none
module hac_mbx_model (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // entry request and answer
    input wire logic scanActive,
    input wire logic [3:0] ackDelay,
    output logic entryAck_ff
);
    logic [3:0] waitCnt_ff;

    // one-cycle ack after ackDelay idle cycles; no ack in the cycle after one
    // so a finished scan is never acked twice
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            waitCnt_ff <= 4'h0;
            entryAck_ff <= 1'b0;
        end
        else if (scanActive && !entryAck_ff && waitCnt_ff >= ackDelay)
        begin
            waitCnt_ff <= 4'h0;
            entryAck_ff <= 1'b1;
        end
        else
        begin
            waitCnt_ff <= scanActive ? waitCnt_ff + 4'h1 : 4'h0;
            entryAck_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** dv/hac_cmd_port_bench.sv ***
// self-checking bench of the host adapter command port
`timescale 1ns/1ps
`default_nettype none
module hac_cmd_port_bench;
    import hac_pkg::*;
    // id values are arbitrary
    localparam logic [7:0] ID0 = 8'h6c;
    localparam logic [7:0] ID1 = 8'h6d;
    localparam logic [7:0] ID2 = 8'h37;
    localparam logic [7:0] ID3 = 8'h32;
    logic [7:0] idb [4] = '{ID0, ID1, ID2, ID3};
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ack;
    logic scanOn;
    logic [23:0] outAddr;
    logic [23:0] inAddr;
    logic [3:0] ackDelay = 4'h0;
    logic [32:0] expQ[$];
    logic [32:0] mskQ[$];
    string nameQ[$];
    logic [31:0] rd;
    logic [31:0] seed = 32'h4b;
    logic [7:0] cnt = 8'h00;
    logic [23:0] base = 24'h0;
    int badCount = 0;
    int checkCount = 0;
    int acks = 0;

    // 20 MHz clock
    always #25 clock = ~clock;

    hac_cmd_port #(.BOARD_TYPE(ID0), .FEATURE_CODE(ID1), .FW_REVISION(ID2), .FW_VERSION(ID3)) DUT (
        .clock(clock), .resetn(resetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mbxEntryAck(ack), .mbxScanActive(scanOn), .mbxOutAddr(outAddr),
        .mbxInAddr(inAddr));

    hac_mbx_model MB (.clock(clock), .resetn(resetn), .scanActive(scanOn),
        .ackDelay(ackDelay), .entryAck_ff(ack));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic hang;
        badCount++;
        $display("wrong value wait expected answer seen timeout");
        report_and_stop();
    endtask

    task automatic check(input string s, input logic [32:0] got, input logic [32:0] e);
        checkCount++;
        if (got !== e)
        begin
            badCount++;
            $display("wrong value %s expected %h seen %h", s, e, got);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            hang();
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    // read with a note for the watcher; pslverr always checked
    task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] m,
        input logic [32:0] e);
        nameQ.push_back(s);
        mskQ.push_back({1'b1, m});
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        while ((rd & m) !== v && n < 50);
        if ((rd & m) !== v)
            hang();
    endtask

    // k: 0 waits for ready, 1 writes at once, 2 waits for busy low
    task automatic cmd(input logic [7:0] b, input logic [1:0] k);
        if (k == 2'd0)
            wait_st(32'h1, 32'h1);
        else if (k == 2'd2)
            wait_st(32'h2, 32'h0);
        apb(1'b1, ADDR_CMD, {24'h0, b});
        repeat (2) @(posedge clock);
    endtask

    task automatic fin(input string s);
        apb(1'b1, ADDR_INTR, 32'h3);
        $display("test %s done", s);
    endtask

    // compares each read answer with the oldest note
    always @(posedge clock)
        if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0)
            check(nameQ.pop_front(), mskQ.pop_front() & {pslverr, prdata}, expQ.pop_front());

    // each serviced entry is checked against its place in the array
    always @(posedge clock)
        if (ack === 1'b1)
        begin
            check("out entry", {9'h0, outAddr}, {9'h0, base + 24'(acks * 4)});
            check("in entry", {9'h0, inAddr}, {9'h0, base + 24'((cnt + acks) * 4)});
            acks++;
        end

    initial
    begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rd_chk("status", ADDR_STATUS, 32'h1f, 33'h09);
        rd_chk("unmapped", 8'h20, 32'hffffffff, 33'h100000000);
        cmd(8'h10, 2'd0);
        rd_chk("intr", ADDR_INTR, 32'h3, 33'h1);
        rd_chk("status", ADDR_STATUS, 32'h11, 33'h11);
        fin("unknown");
        for (int i = 0; i < N_OPS; i++)
            if (i == 0 || i == 3 || i > 5)
            begin
                cmd(OP_TABLE[i], 2'd0);
                rd_chk("intr", ADDR_INTR, 32'h3, 33'h1);
                rd_chk("status", ADDR_STATUS, 32'h1f, 33'h09);
                fin("table");
            end
        cmd(OP_SCAN, 2'd1);
        rd_chk("intr", ADDR_INTR, 32'h3, 33'h1);
        rd_chk("status", ADDR_STATUS, 32'h10, 33'h10);
        fin("early scan");
        cmd(OP_BOARDID, 2'd0);
        wait_st(32'h4, 32'h4);
        rd_chk("status", ADDR_STATUS, 32'h1, 33'h0);
        for (int k = 0; k < 4; k++)
        begin
            wait_st(32'h4, 32'h4);
            rd_chk("reply", ADDR_DATAIN, 32'hff, {25'h0, idb[k]});
        end
        repeat (2) @(posedge clock);
        rd_chk("status", ADDR_STATUS, 32'h5, 33'h1);
        rd_chk("intr", ADDR_INTR, 32'h3, 33'h1);
        fin("board id");
        for (int v = 2; v >= 1; v--)
        begin
            cmd(OP_OUTRDYEN, 2'd1);
            cmd(v[7:0], 2'd2);
            rd_chk("intr", ADDR_INTR, 32'h1, {32'h0, v == 2});
            rd_chk("status", ADDR_STATUS, 32'h50, (v == 2) ? 33'h10 : 33'h40);
            fin("ready enable");
        end
        for (int z = 0; z < 2; z++)
        begin
            seed = xs(seed);
            cnt = (z == 0) ? 8'h00 : {6'h0, seed[1:0]} + 8'h01;
            base = seed[31:8];
            cmd(OP_MBXINIT, 2'd0);
            cmd(cnt, 2'd2);
            for (int b = 2; b >= 0; b--)
                cmd(base[b*8 +: 8], 2'd2);
            rd_chk("intr", ADDR_INTR, 32'h1, 33'h1);
            rd_chk("status", ADDR_STATUS, 32'h18, (z == 0) ? 33'h18 : 33'h0);
            fin("mailbox init");
        end
        rd_chk("config", ADDR_MBXCFG, 32'hffffffff, {1'b0, cnt, base});
        for (int j = 0; j < 2; j++)
        begin
            ackDelay <= (j == 0) ? 4'h5 : 4'h0;
            acks = 0;
            // first pass cuts into a pending board id reply
            if (j == 0)
            begin
                cmd(OP_BOARDID, 2'd0);
                wait_st(32'h4, 32'h4);
            end
            cmd(OP_SCAN, 2'd1);
            for (int n = 0; n < 220 && (acks < cnt || scanOn === 1'b1); n++)
                @(posedge clock);
            if (acks < cnt || scanOn === 1'b1)
                hang();
            repeat (3) @(posedge clock);
            check("acks", 33'(acks), {25'h0, cnt});
            rd_chk("intr", ADDR_INTR, 32'h3, 33'h2);
            rd_chk("status", ADDR_STATUS, 32'h7, 33'h1);
            fin("scan");
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
